// >>> design/srsw_pkg.sv
package srsw_pkg;
  localparam int unsigned CLK_HZ         = 20_000_000;
  localparam int unsigned HOLD_MS        = 200;
  localparam int unsigned WDOG_MS        = 1600;
  localparam int unsigned TRIP_DELAY_US  = 45;
  localparam int unsigned PUSH_MIN_NS    = 550;
  localparam int unsigned KICK_MIN_NS    = 50;
  localparam int unsigned CLK_NS         = 1_000_000_000 / CLK_HZ;
  localparam int unsigned HOLD_CYC       = HOLD_MS * (CLK_HZ / 1000);
  localparam int unsigned WDOG_CYC       = WDOG_MS * (CLK_HZ / 1000);
  localparam int unsigned TRIP_DELAY_CYC = TRIP_DELAY_US * (CLK_HZ / 1_000_000);
  localparam int unsigned PUSH_MIN_CYC   = (PUSH_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned KICK_MIN_CYC   = (KICK_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [2:0]  SYNC_RST       = 3'h0;

  typedef struct packed {
    logic rst_hi;
    logic rst_n;
    logic wdog_n;
    logic aux_fail_n;
  } srsw_out_t;
endpackage

// >>> design/srsw_sync.sv
`timescale 1ns/10ps
`default_nettype none
module srsw_sync (
  input  wire logic CLK_I,
  input  wire logic RSTN_I,
  input  wire logic d_i,
  input  wire logic rst_val_i,
  output logic      q_o
);
  logic [2:0] sh_r;
  logic [2:0] sh_nxt;
  logic       q_r;
  logic       q_nxt;

  always_comb begin
    sh_nxt = {sh_r[1:0], d_i};
    q_nxt  = (sh_r[1] == sh_r[2]) ? sh_r[2] : q_r;
  end

  // reset value comes in as a level but is only taken on a clock edge
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      sh_r <= {3{rst_val_i}};
      q_r  <= rst_val_i;
    end else begin
      sh_r <= sh_nxt;
      q_r  <= q_nxt;
    end
  end

  assign q_o = q_r;
endmodule
`default_nettype wire

// >>> design/srsw_top.sv
`timescale 1ns/10ps
`default_nettype none
module srsw_top #(
  parameter int unsigned HOLD_CYC       = srsw_pkg::HOLD_CYC,
  parameter int unsigned WDOG_CYC       = srsw_pkg::WDOG_CYC,
  parameter int unsigned TRIP_DELAY_CYC = srsw_pkg::TRIP_DELAY_CYC,
  parameter bit          DUAL_POLARITY  = 1'b1
) (
  input  wire logic CLK_I,
  input  wire logic RSTN_I,
  input  wire logic SUPPLY_OK_I,
  input  wire logic AUX_ABOVE_I,
  input  wire logic PUSHBUTTON_RESET_N_I,
  input  wire logic WATCHDOG_KICK_IN_I,
  input  wire logic WATCHDOG_KICK_DRIVEN_I,
  output logic      RESET_O,
  output logic      RESET_N_O,
  output logic      WATCHDOG_FLAG_N_O,
  output logic      AUX_FAIL_FLAG_N_O
);
  typedef enum logic [1:0] {ST_HOLD, ST_RUN, ST_TRIP} srsw_state_t;

  logic supply_s;
  logic aux_s;
  logic push_s;
  logic kick_s;
  logic kick_en_s;

  srsw_sync u_sup (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .d_i(SUPPLY_OK_I),
                   .rst_val_i(1'b0), .q_o(supply_s));
  srsw_sync u_aux (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .d_i(AUX_ABOVE_I),
                   .rst_val_i(1'b0), .q_o(aux_s));
  srsw_sync u_push (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .d_i(PUSHBUTTON_RESET_N_I),
                    .rst_val_i(1'b1), .q_o(push_s));
  srsw_sync u_kick (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .d_i(WATCHDOG_KICK_IN_I),
                    .rst_val_i(1'b0), .q_o(kick_s));
  srsw_sync u_ken (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .d_i(WATCHDOG_KICK_DRIVEN_I),
                   .rst_val_i(1'b0), .q_o(kick_en_s));

  srsw_state_t st_r, st_nxt;
  logic [31:0] hold_r, hold_nxt;
  logic [31:0] trip_r, trip_nxt;
  logic [15:0] push_r, push_nxt;
  logic        push_act_r, push_act_nxt;
  logic        rst_act_r, rst_act_nxt;
  logic [31:0] wd_r, wd_nxt;
  logic        wd_exp_r, wd_exp_nxt;
  logic        kick_d_r, kick_d_nxt;
  srsw_pkg::srsw_out_t out_r, out_nxt;

  // pushbutton: press counts only after the debounced level stays low long enough
  always_comb begin
    push_nxt     = push_s ? 16'h0000 : push_r;
    push_act_nxt = push_act_r;
    if (push_s) begin
      push_act_nxt = 1'b0;
    end else if (push_r >= 16'(srsw_pkg::PUSH_MIN_CYC - 1)) begin
      push_act_nxt = 1'b1;
    end else begin
      push_nxt = push_r + 16'h0001;
    end
  end

  // reset sequencer
  always_comb begin
    st_nxt      = st_r;
    hold_nxt    = hold_r;
    trip_nxt    = 32'h0000_0000;
    rst_act_nxt = rst_act_r;
    unique case (st_r)
      ST_HOLD: begin
        rst_act_nxt = 1'b1;
        if (!supply_s || push_act_r) begin
          hold_nxt = 32'h0000_0000;
        end else if (hold_r >= HOLD_CYC - 1) begin
          st_nxt      = ST_RUN;
          rst_act_nxt = 1'b0;
        end else begin
          hold_nxt = hold_r + 32'h0000_0001;
        end
      end
      ST_RUN: begin
        if (push_act_r) begin
          st_nxt      = ST_HOLD;
          rst_act_nxt = 1'b1;
          hold_nxt    = 32'h0000_0000;
        end else if (!supply_s) begin
          st_nxt = ST_TRIP;
        end
      end
      ST_TRIP: begin
        if (push_act_r || trip_r >= TRIP_DELAY_CYC - 1) begin
          st_nxt      = ST_HOLD;
          rst_act_nxt = 1'b1;
          hold_nxt    = 32'h0000_0000;
        end else if (supply_s) begin
          st_nxt = ST_RUN; // short glitch rejected by the trip delay
        end else begin
          trip_nxt = trip_r + 32'h0000_0001;
        end
      end
    endcase
  end

  // watchdog timer
  always_comb begin
    kick_d_nxt = kick_s;
    wd_nxt     = wd_r + 32'h0000_0001;
    wd_exp_nxt = wd_exp_r;
    if (rst_act_r || !kick_en_s || (kick_s != kick_d_r)) begin
      wd_nxt     = 32'h0000_0000;
      wd_exp_nxt = 1'b0;
    end else if (wd_r >= WDOG_CYC - 1) begin
      wd_nxt     = wd_r;
      wd_exp_nxt = 1'b1;
    end
  end

  always_comb begin
    out_nxt.rst_hi     = DUAL_POLARITY ? rst_act_nxt : 1'b0;
    out_nxt.rst_n      = ~rst_act_nxt;
    out_nxt.wdog_n     = supply_s && !wd_exp_nxt;
    out_nxt.aux_fail_n = aux_s;
  end

  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      st_r       <= ST_HOLD;
      hold_r     <= 32'h0000_0000;
      trip_r     <= 32'h0000_0000;
      push_r     <= 16'h0000;
      push_act_r <= 1'b0;
      rst_act_r  <= 1'b1;
      wd_r       <= 32'h0000_0000;
      wd_exp_r   <= 1'b0;
      kick_d_r   <= 1'b0;
      out_r      <= '{rst_hi: DUAL_POLARITY, rst_n: 1'b0, wdog_n: 1'b0, aux_fail_n: 1'b0};
    end else begin
      st_r       <= st_nxt;
      hold_r     <= hold_nxt;
      trip_r     <= trip_nxt;
      push_r     <= push_nxt;
      push_act_r <= push_act_nxt;
      rst_act_r  <= rst_act_nxt;
      wd_r       <= wd_nxt;
      wd_exp_r   <= wd_exp_nxt;
      kick_d_r   <= kick_d_nxt;
      out_r      <= out_nxt;
    end
  end

  assign RESET_O           = out_r.rst_hi;
  assign RESET_N_O         = out_r.rst_n;
  assign WATCHDOG_FLAG_N_O = out_r.wdog_n;
  assign AUX_FAIL_FLAG_N_O = out_r.aux_fail_n;

  pol_match_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    DUAL_POLARITY |-> (RESET_O == !RESET_N_O)) else $error("reset polarities differ");
  aux_flag_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    AUX_FAIL_FLAG_N_O == $past(aux_s)) else $error("aux flag mismatch");
  wdog_low_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    !supply_s |=> !WATCHDOG_FLAG_N_O) else $error("watchdog flag high in undervoltage");
  wdog_rise_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    (supply_s && !wd_exp_r && !kick_en_s) |=> WATCHDOG_FLAG_N_O)
    else $error("watchdog flag not released");
  release_hold_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    $rose(RESET_N_O) |-> $past(st_r) == ST_HOLD && $past(hold_r) >= HOLD_CYC - 1)
    else $error("reset released early");
  push_rst_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    push_act_r |=> ##1 !RESET_N_O) else $error("pushbutton did not reset");
  trip_rst_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    (st_r == ST_TRIP && trip_r >= TRIP_DELAY_CYC - 1) |=> ##1 !RESET_N_O)
    else $error("trip did not reset");
  wd_clear_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    (kick_s != kick_d_r) |=> wd_r == 32'h0000_0000) else $error("kick did not clear timer");
  // a kick or reset in the expiry cycle lets the flag rise again, so those are left out
  wd_expire_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    (wd_exp_r && kick_en_s && !rst_act_r && (kick_s == kick_d_r)) |=> !WATCHDOG_FLAG_N_O)
    else $error("expiry not flagged");
endmodule
`default_nettype wire

// >>> testbench/srsw_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module srsw_host_model (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        kick_en_i,
  input  wire logic        drive_i,
  input  wire logic [15:0] gap_i,
  output logic             kick_o,
  output logic             driven_o
);
  logic [15:0] cnt_r = 16'h0000;
  logic        lvl_r = 1'b0;
  logic        flt_r = 1'b0;
  // host sits idle while held in reset, kicks every gap_i+1 cycles
  always @(posedge clk_i) begin
    flt_r <= ~flt_r;
    if (!rst_n_i || !kick_en_i || cnt_r >= gap_i) cnt_r <= 16'h0000;
    else cnt_r <= cnt_r + 16'h0001;
    if (rst_n_i && kick_en_i && cnt_r >= gap_i) lvl_r <= ~lvl_r;
  end
  // open pin: no stable level, so show a pattern that changes every cycle
  assign kick_o   = drive_i ? lvl_r : flt_r;
  assign driven_o = drive_i;
endmodule
`default_nettype wire

// >>> testbench/supply_reset_supervisor_watchdog_bench.sv
`timescale 1ns/10ps
`default_nettype none
module supply_reset_supervisor_watchdog_bench;
  localparam int H = 50;
  localparam int W = 200;
  localparam int T = 5;
  logic              clk = 1'b0;
  logic              rstn = 1'b0;
  logic              sup = 1'b0;
  logic              aux = 1'b1;
  logic              pb = 1'b1;
  logic              ken = 1'b0;
  logic              drv = 1'b1;
  logic [15:0]       gap = 16'h0014;
  logic              kick;
  logic              kdrv;
  logic              a;
  logic              rst1_hi;
  logic              rst1_n;
  wire srsw_pkg::srsw_out_t o;
  int                miscompares = 0;
  int                n_compared = 0;
  srsw_top #(.HOLD_CYC(H), .WDOG_CYC(W), .TRIP_DELAY_CYC(T)) dut (
    .CLK_I(clk), .RSTN_I(rstn), .SUPPLY_OK_I(sup), .AUX_ABOVE_I(aux),
    .PUSHBUTTON_RESET_N_I(pb), .WATCHDOG_KICK_IN_I(kick),
    .WATCHDOG_KICK_DRIVEN_I(kdrv), .RESET_O(o.rst_hi), .RESET_N_O(o.rst_n),
    .WATCHDOG_FLAG_N_O(o.wdog_n), .AUX_FAIL_FLAG_N_O(o.aux_fail_n));
  // single-polarity variant: the active-high output must stay low
  srsw_top #(.HOLD_CYC(H), .WDOG_CYC(W), .TRIP_DELAY_CYC(T), .DUAL_POLARITY(1'b0)) dut_single (
    .CLK_I(clk), .RSTN_I(rstn), .SUPPLY_OK_I(sup), .AUX_ABOVE_I(aux),
    .PUSHBUTTON_RESET_N_I(pb), .WATCHDOG_KICK_IN_I(kick),
    .WATCHDOG_KICK_DRIVEN_I(kdrv), .RESET_O(rst1_hi), .RESET_N_O(rst1_n),
    .WATCHDOG_FLAG_N_O(), .AUX_FAIL_FLAG_N_O());
  srsw_host_model host (.clk_i(clk), .rst_n_i(o.rst_n), .kick_en_i(ken),
    .drive_i(drv), .gap_i(gap), .kick_o(kick), .driven_o(kdrv));
  initial begin
    forever #25 clk = ~clk;
  end
  task automatic give_verdict();
    if (miscompares == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(logic [3:0] got, logic [3:0] exp, logic [3:0] m);
    n_compared++;
    if ((got & m) !== (exp & m)) begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got & m, exp & m);
    end
  endtask
  // expected outputs: both reset polarities, watchdog flag, aux flag
  function automatic logic [3:0] exp_o(logic rst, logic wd, logic af);
    return {rst, ~rst, wd, af};
  endfunction
  // bounded wait on one output bit; running out is a mismatch
  task automatic wt(int i, logic v, int lim);
    int n;
    n = 0;
    #1;
    while (o[i] !== v && n < lim) begin
      cyc(1);
      n++;
    end
    chk({3'h0, o[i]}, {3'h0, v}, 4'h1);
    if (o[i] !== v) give_verdict();
  endtask
  initial begin
    void'($urandom(25589));
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    cyc(1);
    chk(o, exp_o(1'b1, 1'b0, 1'b0), 4'he);
    chk({rst1_hi, rst1_n, 2'h0}, exp_o(1'b1, 1'b0, 1'b0) & 4'h4, 4'hc);
    cyc(20);
    chk(o, exp_o(1'b1, 1'b0, 1'b0), 4'he);
    @(posedge clk) sup <= 1'b1;
    ken <= 1'b1;
    cyc(8);
    chk(o, exp_o(1'b1, 1'b1, 1'b0), 4'he);
    cyc(H - 10);
    chk(o, exp_o(1'b1, 1'b1, 1'b0), 4'he);
    wt(2, 1'b1, 20);
    chk(o, exp_o(1'b0, 1'b1, 1'b0), 4'he);
    chk({rst1_hi, rst1_n, 2'h0}, exp_o(1'b0, 1'b0, 1'b0) & 4'h4, 4'hc);
    repeat (16) begin
      a = 1'($urandom);
      @(posedge clk) aux <= a;
      cyc(8);
      chk(o, exp_o(1'b0, 1'b0, a), 4'h1);
    end
    @(posedge clk) pb <= 1'b0;
    repeat ($urandom % 8) @(posedge clk);
    @(posedge clk) pb <= 1'b1;
    cyc(8);
    chk(o, exp_o(1'b0, 1'b0, 1'b0), 4'hc);
    @(posedge clk) pb <= 1'b0;
    cyc(20);
    chk(o, exp_o(1'b1, 1'b0, 1'b0), 4'hc);
    chk({rst1_hi, rst1_n, 2'h0}, exp_o(1'b1, 1'b0, 1'b0) & 4'h4, 4'hc);
    cyc(H + 10);
    chk(o, exp_o(1'b1, 1'b0, 1'b0), 4'hc);
    @(posedge clk) pb <= 1'b1;
    cyc(H);
    chk(o, exp_o(1'b1, 1'b0, 1'b0), 4'hc);
    wt(2, 1'b1, 20);
    @(posedge clk) sup <= 1'b0;
    repeat (2) @(posedge clk);
    sup <= 1'b1;
    cyc(12);
    chk(o, exp_o(1'b0, 1'b0, 1'b0), 4'hc);
    @(posedge clk) sup <= 1'b0;
    wt(2, 1'b0, T + 10);
    chk(o, exp_o(1'b1, 1'b0, 1'b0), 4'he);
    @(posedge clk) sup <= 1'b1;
    wt(2, 1'b1, H + 20);
    cyc(3 * W);
    chk(o, exp_o(1'b0, 1'b1, 1'b0), 4'h2);
    @(posedge clk) gap <= 16'(W - 20);
    cyc(3 * W);
    chk(o, exp_o(1'b0, 1'b1, 1'b0), 4'h2);
    @(posedge clk) drv <= 1'b0;
    cyc(3 * W);
    chk(o, exp_o(1'b0, 1'b1, 1'b0), 4'h2);
    @(posedge clk) drv <= 1'b1;
    gap <= 16'h0014;
    cyc(W / 2);
    @(posedge clk) ken <= 1'b0;
    wt(1, 1'b0, W + 20);
    // mid-run reset: outputs return to reset values and the expired timer is cleared
    @(posedge clk) rstn <= 1'b0;
    cyc(4);
    chk(o, exp_o(1'b1, 1'b0, 1'b0), 4'hf);
    @(posedge clk) rstn <= 1'b1;
    wt(2, 1'b1, H + 20);
    chk(o, exp_o(1'b0, 1'b1, 1'b0), 4'he);
    give_verdict();
  end
endmodule
`default_nettype wire
